// ### verilog/instr_decode_pkg.sv
// Constants shared by the instruction decode and address generation block.
// Assumes a single 100 MHz system clock and synchronous datapath inputs.
`default_nettype none
package instr_decode_pkg;
  // Instruction word layout.
  localparam int WORD_W      = 16;  // Width of an instruction or data word.
  localparam int OP_MSB      = 15;  // Top bit of the op code field.
  localparam int OP_LSB      = 12;  // Bottom bit of the op code field.
  localparam int MODE_MSB    = 11;  // Top bit of the mode field.
  localparam int MODE_LSB    = 9;   // Bottom bit of the mode field.
  localparam int ADDR_MSB    = 8;   // Top bit of the address field.
  localparam int DIRECT_MSB  = 10;  // Top bit passed in direct mode.
  localparam int INDIR_BIT   = 15;  // Bit of an address word that flags another level.
  localparam int UNIT_MSB    = 8;   // Top bit of the logical unit number.
  localparam int UNIT_LSB    = 6;   // Bottom bit of the logical unit number.
  localparam int DEV_MSB     = 5;   // Top bit of the device address.
  localparam int EXT_MODE_MSB = 2;  // Top bit of the extended addressing mode.
  localparam int EXT_GRP_LSB = 3;   // Bottom bit of the extended group code.
  localparam int EXT_GRP_MSB = 8;   // Top bit of the extended group code.

  typedef logic [3:0] opcode_t;     // Op code, read as two octal digits.
  typedef logic [2:0] mode_t;       // Mode field value.

  // Op code values in octal.
  localparam opcode_t OP_NONADDR  = 4'o00;  // Nonaddressing and double word.
  localparam opcode_t OP_SW_FIRST = 4'o01;  // First single-word addressing code.
  localparam opcode_t OP_SW_LAST  = 4'o07;  // Last code in the low half.
  localparam opcode_t OP_IO       = 4'o10;  // Input/output class.
  localparam opcode_t OP_LOAD_LAST  = 4'o03;  // Last load-set code.
  localparam opcode_t OP_STORE_FIRST = 4'o04; // First store-set code.
  localparam opcode_t OP_AL_FIRST = 4'o11;  // First low arithmetic/logic code.
  localparam opcode_t OP_AL_MID   = 4'o15;  // Last low arithmetic/logic code.
  localparam opcode_t OP_AL_HIGH  = 4'o16;  // First high arithmetic/logic code.
  localparam opcode_t OP_AL_LAST  = 4'o17;  // Last high arithmetic/logic code.

  // Mode values.
  localparam mode_t MODE_DIRECT_LAST = 3'd3;  // Modes 0 to 3 are direct.
  localparam mode_t MODE_RELATIVE    = 3'd4;  // Relative to program counter.
  localparam mode_t MODE_INDEX_X     = 3'd5;  // Indexed by index register.
  localparam mode_t MODE_INDEX_B     = 3'd6;  // Indexed by low accumulator.
  localparam mode_t MODE_INDIRECT    = 3'd7;  // Indirect address.
  localparam mode_t MODE_IO_AUX      = 3'd4;  // Highest legal input/output subtype.
  localparam mode_t MODE_NA_EXTEND   = 3'd6;  // Immediate or extended form.

  // Gate bus sources.
  typedef enum logic [1:0] {
    GATE_OPERAND_TRUE,   // Operand register true output.
    GATE_OPERAND_COMP,   // Operand register complement output.
    GATE_ADDR_FIELD      // Instruction address field.
  } gate_src_e;

  // Arithmetic bus sources.
  typedef enum logic [1:0] {
    ABUS_ADDER,          // Adder output.
    ABUS_EXTERNAL,       // External input data.
    ABUS_MEMORY          // Memory word alternate path.
  } abus_src_e;

  // Reset value of the instruction register.
  localparam logic [WORD_W-1:0] INSTR_RESET = 16'h0000;
endpackage : instr_decode_pkg
`default_nettype wire

// ### verilog/op_group_decode.sv
// Combinational op code decode into class, set and group selects.
// Assumes the op code comes straight from the instruction register.
`default_nettype none
module op_group_decode
  import instr_decode_pkg::*;
(
  input  wire  instr_decode_pkg::opcode_t opCode,          // Op code field.
  output logic                            classSingleWord, // Single-word addressing.
  output logic                            classNonaddr,    // Nonaddressing/double word.
  output logic                            classIo,         // Input/output class.
  output logic                            loadSetOp,       // Op code in load set.
  output logic                            storeSetOp,      // Op code in store set.
  output logic                            alLowOp,         // Low arithmetic/logic set.
  output logic                            alHighOp,        // High arithmetic/logic set.
  output logic [3:0]                      groupSel         // One-hot group, one to four.
);
  // Op codes are read as two octal digits with bit 15 most significant.
  always_comb begin
    // Single word addressing spans 01-07 and 11-17.
    classSingleWord = (opCode != OP_NONADDR) && (opCode != OP_IO);
    classNonaddr    = (opCode == OP_NONADDR);
    classIo         = (opCode == OP_IO);
    loadSetOp  = (opCode <= OP_LOAD_LAST);
    storeSetOp = (opCode >= OP_STORE_FIRST) && (opCode <= OP_SW_LAST);
    alLowOp    = (opCode >= OP_AL_FIRST) && (opCode <= OP_AL_MID);
    alHighOp   = (opCode >= OP_AL_HIGH) && (opCode <= OP_AL_LAST);
    // The low two bits pick the group; code 4 in the low digit is group four.
    groupSel = 4'h0;
    if (classSingleWord) begin
      unique case (opCode[1:0])
        2'b01:   groupSel = 4'h1;
        2'b10:   groupSel = 4'h2;
        2'b11:   groupSel = 4'h4;
        default: groupSel = (opCode[2]) ? 4'h8 : 4'h0;  // Codes 04 and 14 only.
      endcase
    end
  end
endmodule : op_group_decode
`default_nettype wire

// ### verilog/instruction_decode_and_address_gen.sv
// Instruction register, field decode and effective address generation.
// Assumes phase strobes from the timing logic are one-cycle pulses on sys_clk
// and that the memory data register and operation registers are synchronous.
// Notes on behaviour
// - Word splits into op, mode, address fields.
// - Class decode: 01-07 and 11-17 single, 00 other, 10 I/O.
// - Load set for 00-03 in instruction execute.
// - Store set for 04-07 in operand execute.
// - Arith sets 11-15 and 16-17, instruction execute.
// - Exactly one group select per single-word code.
// - Single-word mode picks direct, relative, indexed, indirect.
// - Nonaddressing mode picks one of eight types.
// - I/O mode picks one of five subtypes.
// - Address field is address or added offset.
// - Double-word address field gives execute conditions.
// - Extended form: low mode, six group bits.
// - Immediate form like extended, low bits zero.
// - I/O unit from bits 6-8, device 0-5.
// - Instruction register loads at instruction execute start.
// - Instruction word goes via data register.
// - Direct mode passes bits 0-10, both selects.
// - Relative adds bits 0-8 to program counter.
// - Indexed adds bits 0-8 to X or B.
// - Indirect fetch yields an operand address.
// - Gate bus takes operand true, complement, or field.
// - Adder adds source bus or forms AND.
// - Arithmetic bus carries adder, external, memory.
// - Address word bit 15 flags another indirect.
//
// The implementer's own choices: the plain strobed port and the address map.
`default_nettype none
module instruction_decode_and_address_gen
  import instr_decode_pkg::*;
#(
  parameter int WIDTH = 16  // Datapath width.
) (
  input  wire  logic                         sys_clk,             // System clock.
  input  wire  logic                         rst,                 // Async reset, high.
  input  wire  logic                         instrExecutePhase,   // Instruction execute phase.
  input  wire  logic                         operandExecutePhase, // Operand execute phase.
  input  wire  logic                         addressCycle,        // Address cycle active.
  input  wire  logic                         addrWordStrobe,      // Address word fetched.
  input  wire  logic [WIDTH-1:0]             memDataWord,         // Memory data register.
  input  wire  logic [WIDTH-1:0]             progCounter,         // Program counter.
  input  wire  logic [WIDTH-1:0]             indexReg,            // Index register.
  input  wire  logic [WIDTH-1:0]             lowAcc,              // Low accumulator.
  input  wire  logic [WIDTH-1:0]             operandReg,          // Operand register.
  input  wire  logic [WIDTH-1:0]             sourceBus,           // Operation register data.
  input  wire  logic [WIDTH-1:0]             externalData,        // External input data.
  input  wire  instr_decode_pkg::gate_src_e  gateSel,             // Gate bus source.
  input  wire  instr_decode_pkg::abus_src_e  abusSel,             // Arithmetic bus source.
  input  wire  logic                         adderAndMode,        // Adder forms AND.
  output logic [WIDTH-1:0]                   instrWord,           // Instruction register.
  output logic [3:0]                         opCodeField,         // Op code field.
  output logic [2:0]                         modeField,           // Mode field.
  output logic [8:0]                         addrField,           // Address field.
  output logic                               class_single_word_addressing, // Class 01-07, 11-17.
  output logic                               class_nonaddressing_double,   // Class 00.
  output logic                               class_input_output,           // Class 10.
  output logic                               set_load,            // Load set select.
  output logic                               set_store,           // Store set select.
  output logic                               set_arith_logic_low, // Arith set 11-15.
  output logic                               set_arith_logic_high,// Arith set 16-17.
  output logic                               group_one_select,    // Group one.
  output logic                               group_two_select,    // Group two.
  output logic                               group_three_select,  // Group three.
  output logic                               group_four_select,   // Group four.
  output logic [7:0]                         modeDecode,          // One-hot mode 0..7.
  output logic                               modeDirect,          // Direct addressing.
  output logic                               modeRelative,        // Relative addressing.
  output logic                               modeIndexX,          // Index register mode.
  output logic                               modeIndexB,          // Low accumulator mode.
  output logic                               modeIndirect,        // Indirect addressing.
  output logic [7:0]                         nonaddrType,         // One-hot other type.
  output logic [4:0]                         ioSubtype,           // One-hot I/O subtype.
  output logic [8:0]                         condField,           // Double-word conditions.
  output logic [2:0]                         extModeField,        // Extended address mode.
  output logic [5:0]                         extGroupField,       // Extended group codes.
  output logic                               extFormValid,        // Top group bits zero.
  output logic                               immediateForm,       // Immediate form seen.
  output logic [2:0]                         ioUnit,              // Logical unit number.
  output logic [5:0]                         ioDevice,            // Device address.
  output logic                               low_field_select,    // Low field gate.
  output logic                               high_field_select,   // High field gate.
  output logic [WIDTH-1:0]                   effAddr,             // Effective address.
  output logic                               effAddrIsPointer,    // Fetch yields an address.
  output logic                               nextIndirect,        // Next access indirect.
  output logic [WIDTH-1:0]                   gateBus,             // Gate bus.
  output logic [WIDTH-1:0]                   adderOut,            // Adder result.
  output logic [WIDTH-1:0]                   arithBus             // Arithmetic bus.
);
  import instr_decode_pkg::*;

  // All registered state of the block.
  typedef struct packed {
    logic [WIDTH-1:0] instr;      // Held instruction word.
    logic             phaseQ;     // Execute phase last cycle, for edge detect.
    logic [WIDTH-1:0] effAddr;    // Registered effective address.
    logic             pointer;    // Registered pointer flag.
    logic             nextInd;    // Registered indirect chain flag.
  } state_s;

  state_s stateQ;  // Present state.
  state_s stateD;  // Next state.

  // Combinational decode products.
  logic       isSingle;   // Single-word class.
  logic       isNonaddr;  // Nonaddressing/double class.
  logic       isIo;       // Input/output class.
  logic       loadOp;     // Op in load set.
  logic       storeOp;    // Op in store set.
  logic       alLow;      // Op in low arithmetic set.
  logic       alHigh;     // Op in high arithmetic set.
  logic [3:0] groups;     // Group selects.
  logic       loadStrobe; // Leading edge of instruction execute.
  logic [WIDTH-1:0] offset; // Zero-extended address field.
  logic [WIDTH-1:0] gateNext; // Gate bus value.
  logic [WIDTH-1:0] adderNext; // Adder value.

  // The instruction register loads on the rising edge of the execute phase.
  assign loadStrobe = instrExecutePhase && !stateQ.phaseQ;

  // Field split of the held word.
  assign opCodeField = stateQ.instr[OP_MSB:OP_LSB];
  assign modeField   = stateQ.instr[MODE_MSB:MODE_LSB];
  assign addrField   = stateQ.instr[ADDR_MSB:0];
  assign instrWord   = stateQ.instr;
  assign offset      = {{(WIDTH-9){1'b0}}, addrField};

  // Op code decoding lives in its own small module.
  op_group_decode opDecode (
    .opCode          (opCodeField),
    .classSingleWord (isSingle),
    .classNonaddr    (isNonaddr),
    .classIo         (isIo),
    .loadSetOp       (loadOp),
    .storeSetOp      (storeOp),
    .alLowOp         (alLow),
    .alHighOp        (alHigh),
    .groupSel        (groups)
  );

  // Class and group outputs follow the held op code directly.
  assign class_single_word_addressing = isSingle;
  assign class_nonaddressing_double   = isNonaddr;
  assign class_input_output           = isIo;
  assign group_one_select   = groups[0];
  assign group_two_select   = groups[1];
  assign group_three_select = groups[2];
  assign group_four_select  = groups[3];

  // Set selects are qualified by the phase in which each set acts.
  assign set_load  = loadOp && instrExecutePhase;
  assign set_store = storeOp && operandExecutePhase;
  assign set_arith_logic_low  = alLow && instrExecutePhase;
  assign set_arith_logic_high = alHigh && instrExecutePhase;

  // Mode decode, interpreted per class.
  always_comb begin
    modeDecode   = 8'h01 << modeField;
    modeDirect   = isSingle && (modeField <= MODE_DIRECT_LAST);
    modeRelative = isSingle && (modeField == MODE_RELATIVE);
    modeIndexX   = isSingle && (modeField == MODE_INDEX_X);
    modeIndexB   = isSingle && (modeField == MODE_INDEX_B);
    modeIndirect = isSingle && (modeField == MODE_INDIRECT);
    // Nonaddressing types: halt, jump, mark, execute, shift, change, ext, overflow.
    nonaddrType  = isNonaddr ? modeDecode : 8'h00;
    // I/O subtypes above auxiliary control are undefined and decode to none.
    if (isIo && (modeField <= MODE_IO_AUX)) begin
      ioSubtype = modeDecode[4:0];
    end else begin
      ioSubtype = 5'h00;
    end
  end

  // Address field interpretations for the other instruction forms.
  assign condField     = isNonaddr ? addrField : 9'h000;
  assign extModeField  = addrField[EXT_MODE_MSB:0];
  assign extGroupField = addrField[EXT_GRP_MSB:EXT_GRP_LSB];
  assign extFormValid  = isNonaddr && (modeField == MODE_NA_EXTEND)
                         && (addrField[EXT_GRP_MSB:EXT_GRP_MSB-1] == 2'b00);
  assign immediateForm = extFormValid && (extModeField == 3'd0);
  assign ioUnit        = addrField[UNIT_MSB:UNIT_LSB];
  assign ioDevice      = addrField[DEV_MSB:0];

  // Field selects: direct and indirect use both, other modes only the low field.
  assign low_field_select  = isSingle;
  assign high_field_select = modeDirect || modeIndirect;

  // Arithmetic section: gate bus, adder and arithmetic bus.
  always_comb begin
    unique case (gateSel)
      GATE_OPERAND_TRUE: gateNext = operandReg;
      GATE_OPERAND_COMP: gateNext = ~operandReg;
      default:           gateNext = offset;
    endcase
    // The adder either sums or forms the logical product.
    adderNext = adderAndMode ? (operandReg & sourceBus)
                             : WIDTH'(gateNext + sourceBus);
    unique case (abusSel)
      ABUS_ADDER:    arithBus = adderNext;
      ABUS_EXTERNAL: arithBus = externalData;
      default:       arithBus = memDataWord;
    endcase
  end
  assign gateBus  = gateNext;
  assign adderOut = adderNext;

  // Next-state logic: instruction capture and effective address formation.
  always_comb begin
    stateD        = stateQ;
    stateD.phaseQ = instrExecutePhase;
    // Word read into the data register is passed into the instruction register.
    if (loadStrobe) begin
      stateD.instr = memDataWord;
    end
    // Effective address for the held instruction.
    if (modeDirect || modeIndirect) begin
      stateD.effAddr = {{(WIDTH-11){1'b0}}, stateQ.instr[DIRECT_MSB:0]};
    end else if (modeRelative) begin
      stateD.effAddr = WIDTH'(progCounter + offset);
    end else if (modeIndexX) begin
      stateD.effAddr = WIDTH'(indexReg + offset);
    end else if (modeIndexB) begin
      stateD.effAddr = WIDTH'(lowAcc + offset);
    end else begin
      stateD.effAddr = offset;
    end
    stateD.pointer = modeIndirect;
    // Each fetched address word decides whether another level follows.
    if (addressCycle && addrWordStrobe) begin
      stateD.nextInd = memDataWord[INDIR_BIT];
    end else if (!addressCycle) begin
      stateD.nextInd = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateQ <= '{instr: WIDTH'(INSTR_RESET), phaseQ: 1'b0, effAddr: '0, pointer: 1'b0,
                  nextInd: 1'b0};
    end else begin
      stateQ <= stateD;
    end
  end

  assign effAddr          = stateQ.effAddr;
  assign effAddrIsPointer = stateQ.pointer;
  assign nextIndirect     = stateQ.nextInd;
endmodule : instruction_decode_and_address_gen
`default_nettype wire

// ### tb/datapath_model.sv
// Far-side model: operation registers and buses that feed the decoder.
// Assumes the registers stay steady while the decoder forms addresses.
`default_nettype none
module datapath_model #(
  parameter logic [15:0] PC_V = 16'h1200,  // Program counter contents.
  parameter logic [15:0] X_V  = 16'h0340,  // Index register contents.
  parameter logic [15:0] B_V  = 16'hFF80,  // Low accumulator, near wrap on purpose.
  parameter logic [15:0] R_V  = 16'hA5C3,  // Operand register contents.
  parameter logic [15:0] S_V  = 16'h0F0F,  // Source bus data.
  parameter logic [15:0] E_V  = 16'h5A5A   // External input data.
) (
  output logic [15:0] progCounter,
  output logic [15:0] indexReg,
  output logic [15:0] lowAcc,
  output logic [15:0] operandReg,
  output logic [15:0] sourceBus,
  output logic [15:0] externalData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registers hold their words for the whole run.
  assign progCounter  = PC_V;
  assign indexReg     = X_V;
  assign lowAcc       = B_V;
  assign operandReg   = R_V;
  assign sourceBus    = S_V;
  assign externalData = E_V;
endmodule : datapath_model
`default_nettype wire

// ### tb/instr_decode_sva.sv
// Checker for the decoder top ports.
// Assumes one clock domain with an asynchronous active-high reset.
`default_nettype none
module instr_decode_sva #(
  parameter int WIDTH = 16  // Datapath width.
) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             instrExecutePhase,
  input wire logic             operandExecutePhase,
  input wire logic             addressCycle,
  input wire logic             addrWordStrobe,
  input wire logic [WIDTH-1:0] memDataWord,
  input wire logic [WIDTH-1:0] instrWord,
  input wire logic             class_single_word_addressing,
  input wire logic             class_input_output,
  input wire logic             set_load,
  input wire logic             set_store,
  input wire logic             set_arith_logic_low,
  input wire logic             set_arith_logic_high,
  input wire logic             group_one_select,
  input wire logic             group_two_select,
  input wire logic             group_three_select,
  input wire logic             group_four_select,
  input wire logic [7:0]       modeDecode,
  input wire logic             nextIndirect
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_load; $rose(instrExecutePhase) |=> instrWord == $past(memDataWord); endproperty
  a_load: assert property (p_load) else $error("instruction word not loaded");
  property p_hold; !$rose(instrExecutePhase) |=> $stable(instrWord); endproperty
  a_hold: assert property (p_hold) else $error("instruction word changed");
  property p_io; class_input_output == (instrWord[15:12] == 4'h8); endproperty
  a_io: assert property (p_io) else $error("io class wrong");
  property p_ld; set_load == (instrExecutePhase && instrWord[15:14] == 2'b00); endproperty
  a_ld: assert property (p_ld) else $error("load set wrong");
  property p_st; set_store == (operandExecutePhase && instrWord[15:14] == 2'b01); endproperty
  a_st: assert property (p_st) else $error("store set wrong");
  property p_al; {set_arith_logic_high, set_arith_logic_low} == (instrExecutePhase ?
    {instrWord[15:13] == 3'b111, instrWord[15:12] > 4'o10 && instrWord[15:12] < 4'o16} : 2'b00);
  endproperty
  a_al: assert property (p_al) else $error("arithmetic set wrong");
  property p_grp; class_single_word_addressing |-> {group_four_select, group_three_select,
    group_two_select, group_one_select} == 4'h1 << ((instrWord[14:12] - 3'd1) & 3'd3); endproperty
  a_grp: assert property (p_grp) else $error("group select wrong");
  property p_mode; modeDecode == 8'h01 << instrWord[11:9]; endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_ind; addressCycle && addrWordStrobe && memDataWord[15] |=> nextIndirect; endproperty
  a_ind: assert property (p_ind) else $error("indirect flag missed");
  property p_clr; !addressCycle |=> !nextIndirect; endproperty
  a_clr: assert property (p_clr) else $error("indirect flag not cleared");
endmodule : instr_decode_sva
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench: loads words and compares decode and bus outputs.
// Assumes the far-side model supplies steady register contents.
`default_nettype none
`define CHK(nm, got, exp) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module testbench import instr_decode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIDTH = 16;
  localparam logic [15:0] PC_V = 16'h1200, X_V = 16'h0340, B_V = 16'hFF80;
  localparam logic [15:0] R_V = 16'hA5C3, S_V = 16'h0F0F, E_V = 16'h5A5A;
  logic sys_clk = 1'b0, rst = 1'b1, instrExecutePhase = 1'b0, operandExecutePhase = 1'b0;
  logic addressCycle = 1'b0, addrWordStrobe = 1'b0, adderAndMode = 1'b0;
  logic [15:0] memDataWord = 16'h0000, progCounter, indexReg, lowAcc, operandReg, sourceBus;
  logic [15:0] externalData, instrWord, effAddr, gateBus, adderOut, arithBus, w, ea, gb, ad;
  gate_src_e gateSel = GATE_OPERAND_TRUE;
  abus_src_e abusSel = ABUS_ADDER;
  logic [3:0] opCodeField;
  logic [2:0] modeField, extModeField, ioUnit, m;
  logic [8:0] addrField, condField;
  logic [7:0] modeDecode, nonaddrType;
  logic [4:0] ioSubtype;
  logic [5:0] extGroupField, ioDevice;
  logic class_single_word_addressing, class_nonaddressing_double, class_input_output, sw;
  logic set_load, set_store, set_arith_logic_low, set_arith_logic_high, extFormValid;
  logic group_one_select, group_two_select, group_three_select, group_four_select;
  logic modeDirect, modeRelative, modeIndexX, modeIndexB, modeIndirect, immediateForm;
  logic low_field_select, high_field_select, effAddrIsPointer, nextIndirect;
  int errTotal = 0, nTests = 0, cyc = 0;
  datapath_model #(.PC_V(PC_V), .X_V(X_V), .B_V(B_V), .R_V(R_V), .S_V(S_V), .E_V(E_V)) PM (.*);
  instruction_decode_and_address_gen #(.WIDTH(WIDTH)) DUT (.*);
  // Clock and hang guard; a hang counts as a mismatch.
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errTotal++;
      test_done();
    end
  end
  // Drops both phases, raises instruction execute with word w, then operand execute a cycle later as the word is inverted.
  task automatic load(input logic [15:0] lw);
    @(posedge sys_clk);
    instrExecutePhase <= 1'b0;
    operandExecutePhase <= 1'b0;
    @(posedge sys_clk);
    instrExecutePhase <= 1'b1;
    memDataWord <= lw;
    @(posedge sys_clk);
    memDataWord <= ~lw;
    operandExecutePhase <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : load
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // Every op code, with held phases and a changed data word.
    for (int i = 0; i < 16; i++) begin
      m = 3'(i);
      w = {4'(i), m, 9'h1C3};
      sw = (i != 0) && (i != 8);
      load(w);
      `CHK("fields", {opCodeField, modeField, addrField}, w)
      `CHK("class", {class_single_word_addressing, class_nonaddressing_double,
        class_input_output}, {sw, i == 0, i == 8})
      `CHK("sets", {set_load, set_store, set_arith_logic_low, set_arith_logic_high},
        {i < 4, i > 3 && i < 8, i > 8 && i < 14, i > 13})
      if (sw) `CHK("group", {group_four_select, group_three_select, group_two_select,
        group_one_select}, 4'h1 << ((i - 1) % 4))
      `CHK("modes", {modeDirect, modeRelative, modeIndexX, modeIndexB, modeIndirect},
        sw ? {m < 4, m == 4, m == 5, m == 6, m == 7} : 5'h00)
      case (m)
        3'd4: ea = PC_V + 16'(w[8:0]);
        3'd5: ea = X_V + 16'(w[8:0]);
        3'd6: ea = B_V + 16'(w[8:0]);
        default: ea = 16'(w[10:0]);
      endcase
      if (!sw) ea = 16'(w[8:0]);
      `CHK("effAddr", effAddr, ea)
      `CHK("gates", {low_field_select, high_field_select, effAddrIsPointer},
        {sw, sw && (m < 4 || m == 7), sw && m == 7})
    end
    // All mode values for the nonaddressing and input/output classes, then two extended
    // forms: one with a nonzero low mode, one with a top group bit set.
    for (int k = 0; k < 18; k++) begin
      m = 3'(k);
      w = k < 8 ? {4'h0, m, 9'o050} : k < 16 ? {4'h8, m, 9'o652}
        : {4'h0, 3'd6, k == 16 ? 9'o053 : 9'o253};
      load(w);
      if (k < 8) `CHK("nonaddr", {nonaddrType, condField, extFormValid, immediateForm,
        extModeField, extGroupField},
        {8'h01 << m, 9'o050, m == 6, m == 6, 3'o0, 6'o05})
      else if (k < 16) `CHK("io", {ioSubtype, ioUnit, ioDevice},
        {m < 5 ? 5'h01 << m : 5'h00, 3'o6, 6'o52})
      else `CHK("extended", {extFormValid, immediateForm, extModeField, extGroupField},
        {k == 16, 1'b0, 3'o3, k == 16 ? 6'o05 : 6'o25})
    end
    // Each gate source, arithmetic bus source and adder mode.
    for (int g = 0; g < 3; g++) begin
      @(posedge sys_clk);
      gateSel <= gate_src_e'(g);
      abusSel <= abus_src_e'(g);
      adderAndMode <= (g == 1);
      @(negedge sys_clk);
      gb = g == 0 ? R_V : g == 1 ? ~R_V : 16'(w[8:0]);
      ad = g == 1 ? R_V & S_V : gb + S_V;
      `CHK("gate", {gateBus, adderOut}, {gb, ad})
      `CHK("abus", arithBus, g == 0 ? ad : g == 1 ? E_V : memDataWord)
    end
    // Address word with the top bit set, then the address cycle ends.
    @(posedge sys_clk);
    addressCycle <= 1'b1;
    addrWordStrobe <= 1'b1;
    memDataWord <= 16'h8000;
    @(posedge sys_clk);
    addrWordStrobe <= 1'b0;
    memDataWord <= 16'h0001;
    @(negedge sys_clk);
    `CHK("indirect", nextIndirect, 1'b1)
    @(posedge sys_clk);
    addressCycle <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("cleared", nextIndirect, 1'b0)
    test_done();
  end
endmodule : testbench
bind instruction_decode_and_address_gen instr_decode_sva #(.WIDTH(WIDTH)) SVA (.*);
`default_nettype wire
